// ==== inc/afe_pins_pkg.sv ====
// Shared constants for the converter front-end pin logic
package afe_pins_pkg;
  localparam int unsigned CLK_SYS_HZ      = 50000000;
  localparam int unsigned SCK_MAX_HZ      = 20000000;
  // Fewest system clocks that one serial clock period may last
  localparam int unsigned SCK_MIN_CYCLES  = (CLK_SYS_HZ + SCK_MAX_HZ - 1) / SCK_MAX_HZ;

  localparam int unsigned PRESCALE_W      = 2;
  localparam int unsigned OSR_SEL_W       = 3;
  localparam int unsigned PRE_CNT_W       = 3;
  localparam int unsigned SAMPLE_DIV      = 4;
  localparam int unsigned SAMPLE_CNT_W    = 2;
  localparam int unsigned OSR_CNT_W       = 12;
  localparam int unsigned OSR_MIN         = 32;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 2'h0;
  localparam logic [OSR_SEL_W-1:0]  OSR_RESET      = 3'h3;

  localparam int unsigned BYTE_W          = 8;
  localparam int unsigned BIT_CNT_W       = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  localparam int unsigned CMD_READ_BIT    = 0;
  localparam logic [BYTE_W-1:0] IDLE_BYTE = 8'h00;
  localparam int unsigned FIFO_DEPTH      = 16;
  localparam int unsigned NUM_CH          = 2;

  typedef enum logic [1:0] {SPI_IDLE, SPI_CMD, SPI_WRITE, SPI_READ} spi_state_t;
endpackage

// ==== hw/afe_clock_ready_serial_pins.sv ====
// Clock tree, ready pulse, modulator pins and serial port of the front end
// Notes on behaviour
// - Modulator pin floats while its channel's output enable is zero.
// - Enabled modulator pin drives its bitstream, refreshed every analog clock tick.
// - Ready pin idles high if drive select is 1, floats if 0 (default).
// - Each completed conversion gives one active-low fixed-width ready pulse.
// - Ready pulse lasts one sample period and repeats at output rate.
// - Ready pulse ignores serial port activity; nothing latches or clears it.
// - Master clock from crystal when external select is 0, crystal input when 1.
// - Analog clock is master clock divided by 1, 2, 4 or 8 per prescale.
// - Sample clock is analog clock divided by 4, four modulator bits each.
// - Output rate is sample clock over ratio 32..4096, code 3 gives 256.
// - Chip select high ignores traffic; falling edge starts, rising edge ends.
// - Input sampled on serial clock rise, output changed on fall.
// - Modes 0,0 and 1,1 accepted; change only while chip select high.
// - Serial output floats in command byte, writes, deselect and reset.
// - Read data leaves in whole 8-bit packets.
// - Half duplex: input and output never both meaningful in a transaction.
// - Each transaction opens with an 8-bit read or write command.
// - Serial input toggling after a read command is ignored.
`timescale 1ns/10ps
`default_nettype none

module byte_fifo
  import afe_pins_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
)(
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             full_r;
  logic             empty_r;
  wire              push = in_valid && !full_r;
  wire              pop  = out_ready && !empty_r;

  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready  = !full_r;
  assign out_valid = !empty_r;
  assign out_data  = mem[rd_ptr_r];

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      full_r   <= 1'b0;
      empty_r  <= 1'b1;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      count_r  <= count_nxt;
      full_r   <= (count_nxt == FULL_COUNT);
      empty_r  <= (count_nxt == '0);
    end
  end
endmodule // byte_fifo

module afe_clock_ready_serial_pins
  import afe_pins_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  // Clock selection and dividers
  input  wire logic                  external_clock_select,
  input  wire logic                  crystal_in,
  output logic                       crystal_out,
  input  wire logic [PRESCALE_W-1:0] prescale_select,
  input  wire logic [OSR_SEL_W-1:0]  oversampling_ratio,
  output logic                       sample_tick,
  output logic                       output_rate_tick,
  // Modulator bitstreams
  input  wire logic [NUM_CH-1:0]     modulator_stream,
  input  wire logic [NUM_CH-1:0]     modulator_output_enable,
  output logic                       modulator_bit_out_ch0,
  output logic                       modulator_bit_out_ch0_oe,
  output logic                       modulator_bit_out_ch1,
  output logic                       modulator_bit_out_ch1_oe,
  // Ready pin
  input  wire logic                  ready_pin_drive_select,
  output logic                       conversion_ready_n,
  output logic                       conversion_ready_n_oe,
  // Serial pins
  input  wire logic                  spi_cs_n,
  input  wire logic                  spi_sck,
  input  wire logic                  spi_sdi,
  output logic                       spi_sdo,
  output logic                       spi_sdo_oe,
  // User side
  output logic [BYTE_W-1:0]          cmd_byte,
  output logic                       cmd_valid,
  output logic [BYTE_W-1:0]          rx_byte,
  output logic                       rx_valid,
  output logic                       frame_end,
  input  wire logic [BYTE_W-1:0]     tx_data,
  input  wire logic                  tx_valid,
  output logic                       tx_ready
);
  // Two-stage synchronisers for every pin input
  logic [1:0] xtal_s_r;
  logic [1:0] cs_s_r;
  logic [1:0] sck_s_r;
  logic [1:0] sdi_s_r;
  logic       xtal_d_r;
  logic       cs_d_r;
  logic       sck_d_r;

  always_ff @(posedge clk_sys)
  begin
    xtal_s_r <= {xtal_s_r[0], crystal_in};
    cs_s_r   <= {cs_s_r[0], spi_cs_n};
    sck_s_r  <= {sck_s_r[0], spi_sck};
    sdi_s_r  <= {sdi_s_r[0], spi_sdi};
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      xtal_d_r <= 1'b0;
      cs_d_r   <= 1'b1;
      sck_d_r  <= 1'b0;
    end
    else
    begin
      xtal_d_r <= xtal_s_r[1];
      cs_d_r   <= cs_s_r[1];
      sck_d_r  <= sck_s_r[1];
    end
  end

  // Crystal mode runs the tree off the system clock; external mode counts pin edges
  wire mclk_tick = external_clock_select ? (xtal_s_r[1] && !xtal_d_r) : 1'b1;

  logic [PRE_CNT_W-1:0]    pre_cnt_r;
  logic [SAMPLE_CNT_W-1:0] smp_cnt_r;
  logic [OSR_CNT_W-1:0]    osr_cnt_r;
  wire  [PRE_CNT_W-1:0]    pre_last = PRE_CNT_W'((1 << prescale_select) - 1);
  wire  [OSR_CNT_W-1:0]    osr_last = OSR_CNT_W'((OSR_MIN << oversampling_ratio) - 1);
  wire                     analog_clock_tick = mclk_tick && (pre_cnt_r >= pre_last);
  wire                     sample_clock_tick = analog_clock_tick &&
                                        (smp_cnt_r == SAMPLE_CNT_W'(SAMPLE_DIV - 1));
  wire                     output_rate_clock_tick = sample_clock_tick && (osr_cnt_r >= osr_last);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pre_cnt_r <= '0;
      smp_cnt_r <= '0;
      osr_cnt_r <= '0;
    end
    else
    begin
      if (mclk_tick)
      begin
        pre_cnt_r <= analog_clock_tick ? '0 : pre_cnt_r + 1'b1;
      end
      if (analog_clock_tick)
      begin
        smp_cnt_r <= smp_cnt_r + 1'b1;
      end
      if (sample_clock_tick)
      begin
        osr_cnt_r <= output_rate_clock_tick ? '0 : osr_cnt_r + 1'b1;
      end
    end
  end

  // Ready pulse: pending from result until next sample tick, then low one sample period
  logic result_pend_r;
  logic ready_low_r;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      result_pend_r    <= 1'b0;
      ready_low_r      <= 1'b0;
      sample_tick      <= 1'b0;
      output_rate_tick <= 1'b0;
      crystal_out      <= 1'b0;
    end
    else
    begin
      sample_tick      <= sample_clock_tick;
      output_rate_tick <= output_rate_clock_tick;
      crystal_out      <= !external_clock_select && !xtal_s_r[1];
      if (output_rate_clock_tick)
      begin
        result_pend_r <= 1'b1;
      end
      else if (sample_clock_tick)
      begin
        result_pend_r <= 1'b0;
      end
      if (sample_clock_tick)
      begin
        ready_low_r <= result_pend_r;
      end
    end
  end

  // Driven only from the pulse and drive select, never from the serial port
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      conversion_ready_n    <= 1'b1;
      conversion_ready_n_oe <= 1'b0;
    end
    else
    begin
      conversion_ready_n    <= !ready_low_r;
      conversion_ready_n_oe <= ready_low_r || ready_pin_drive_select;
    end
  end

  // Modulator pins, one flop pair per channel
  logic [NUM_CH-1:0] mod_bit_r;
  logic [NUM_CH-1:0] mod_oe_r;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_mod
      always_ff @(posedge clk_sys)
      begin
        if (reset)
        begin
          mod_bit_r[ch] <= 1'b0;
          mod_oe_r[ch]  <= 1'b0;
        end
        else
        begin
          mod_oe_r[ch] <= modulator_output_enable[ch];
          if (analog_clock_tick)
          begin
            mod_bit_r[ch] <= modulator_stream[ch];
          end
        end
      end
    end
  endgenerate

  assign modulator_bit_out_ch0    = mod_bit_r[0];
  assign modulator_bit_out_ch1    = mod_bit_r[1];
  assign modulator_bit_out_ch0_oe = mod_oe_r[0];
  assign modulator_bit_out_ch1_oe = mod_oe_r[1];

  // Serial port; the edge pair is the same for modes 0,0 and 1,1
  wire cs_low   = !cs_s_r[1];
  wire cs_fall  = !cs_s_r[1] && cs_d_r;
  wire sck_rise = cs_low && sck_s_r[1] && !sck_d_r;
  wire sck_fall = cs_low && !sck_s_r[1] && sck_d_r;

  spi_state_t           state_r;
  spi_state_t           state_nxt;
  logic [BIT_CNT_W-1:0] bit_cnt_r;
  logic [BYTE_W-1:0]    shift_in_r;
  logic [BYTE_W-1:0]    shift_out_r;
  logic                 out_active_r;
  logic [BYTE_W-1:0]    fifo_data;
  logic                 fifo_valid;
  wire  [BYTE_W-1:0]    byte_in    = {shift_in_r[BYTE_W-2:0], sdi_s_r[1]};
  wire                  byte_done  = sck_rise && (bit_cnt_r == LAST_BIT);
  wire                  load_out   = sck_fall && (state_r == SPI_READ) && !out_active_r;
  wire                  fifo_pop   = load_out && fifo_valid;
  // An empty buffer still yields a whole byte so the packet length holds
  wire  [BYTE_W-1:0]    next_out   = fifo_valid ? fifo_data : IDLE_BYTE;

  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SPI_IDLE:
      begin
        if (cs_fall)
        begin
          state_nxt = SPI_CMD;
        end
      end
      SPI_CMD:
      begin
        if (byte_done)
        begin
          state_nxt = byte_in[CMD_READ_BIT] ? SPI_READ : SPI_WRITE;
        end
      end
      default:
      begin
        state_nxt = state_r;
      end
    endcase
    if (!cs_low)
    begin
      state_nxt = SPI_IDLE;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_r      <= SPI_IDLE;
      bit_cnt_r    <= '0;
      shift_in_r   <= '0;
      shift_out_r  <= '0;
      out_active_r <= 1'b0;
      cmd_byte     <= '0;
      cmd_valid    <= 1'b0;
      rx_byte      <= '0;
      rx_valid     <= 1'b0;
      frame_end    <= 1'b0;
      spi_sdo      <= 1'b0;
      spi_sdo_oe   <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      cmd_valid <= byte_done && (state_r == SPI_CMD);
      rx_valid  <= byte_done && (state_r == SPI_WRITE);
      frame_end <= !cs_s_r[1] ? 1'b0 : !cs_d_r;
      if (!cs_low)
      begin
        bit_cnt_r    <= '0;
        out_active_r <= 1'b0;
      end
      else if (sck_rise && (state_r != SPI_READ))
      begin
        bit_cnt_r  <= bit_cnt_r + 1'b1;
        shift_in_r <= byte_in;
        if (byte_done && (state_r == SPI_CMD))
        begin
          cmd_byte <= byte_in;
        end
        if (byte_done && (state_r == SPI_WRITE))
        begin
          rx_byte <= byte_in;
        end
      end
      else if (sck_fall && (state_r == SPI_READ))
      begin
        // Input is not shifted in read; only falling edges count the packet
        bit_cnt_r    <= bit_cnt_r + 1'b1;
        out_active_r <= (bit_cnt_r != LAST_BIT);
        if (load_out)
        begin
          spi_sdo     <= next_out[BYTE_W-1];
          shift_out_r <= {next_out[BYTE_W-2:0], 1'b0};
        end
        else
        begin
          spi_sdo     <= shift_out_r[BYTE_W-1];
          shift_out_r <= {shift_out_r[BYTE_W-2:0], 1'b0};
        end
      end
      spi_sdo_oe <= cs_low && (state_nxt == SPI_READ) && (state_r == SPI_READ);
    end
  end
endmodule // afe_clock_ready_serial_pins

`default_nettype wire

// ==== tb/afe_pins_asserts.sv ====
// Concurrent checks on the front-end pins
`timescale 1ns/10ps
`default_nettype none
module afe_pins_asserts
  import afe_pins_pkg::*;
(
  input wire logic                  clk_sys,
  input wire logic                  reset,
  input wire logic                  external_clock_select,
  input wire logic [PRESCALE_W-1:0] prescale_select,
  input wire logic                  sample_tick,
  input wire logic                  output_rate_tick,
  input wire logic [NUM_CH-1:0]     modulator_output_enable,
  input wire logic                  modulator_bit_out_ch0_oe,
  input wire logic                  modulator_bit_out_ch1_oe,
  input wire logic                  ready_pin_drive_select,
  input wire logic                  conversion_ready_n,
  input wire logic                  conversion_ready_n_oe,
  input wire logic                  spi_sdo_oe,
  input wire logic [BYTE_W-1:0]     cmd_byte,
  input wire logic                  cmd_valid,
  input wire logic                  rx_valid,
  input wire logic                  frame_end
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [5:0] low_cnt_r;
  logic       read_r;
  wire  [5:0] samp_len = 6'h04 << prescale_select;
  always_ff @(posedge clk_sys)
  begin
    low_cnt_r <= conversion_ready_n ? 6'h00 : low_cnt_r + 6'h01;
    if (reset || frame_end)
      read_r <= 1'b0;
    else if (cmd_valid)
      read_r <= cmd_byte[CMD_READ_BIT];
  end
  // Slow enough for a sample period taken from the crystal pin
  sequence s_pulse_start;
    ##[1:100] $fell(conversion_ready_n);
  endsequence
  a_mod_float: assert property (!modulator_output_enable[0] |=> !modulator_bit_out_ch0_oe)
    else $error("ch0 pin driven while disabled");
  a_mod_drive: assert property (modulator_output_enable[1] |=> modulator_bit_out_ch1_oe)
    else $error("ch1 pin not driven");
  a_ready_idle: assert property (conversion_ready_n && $past(conversion_ready_n)
    && !$past(reset) |-> conversion_ready_n_oe == $past(ready_pin_drive_select))
    else $error("ready idle drive wrong");
  a_pulse_follows: assert property (output_rate_tick |-> s_pulse_start)
    else $error("no ready pulse after result");
  a_pulse_width: assert property ($rose(conversion_ready_n) && !external_clock_select
    |-> low_cnt_r == samp_len)
    else $error("ready pulse width wrong");
  a_tick_align: assert property ($fell(conversion_ready_n)
    |-> $past(sample_tick) || $past(sample_tick, 2))
    else $error("ready pulse off sample tick");
  a_sdo_reads: assert property (spi_sdo_oe
    |-> read_r || $past(read_r) || $past(read_r, 2))
    else $error("serial output driven outside read");
  a_read_no_rx: assert property (rx_valid |-> !read_r)
    else $error("input taken during read");
endmodule // afe_pins_asserts
`default_nettype wire

// ==== tb/spi_host_model.sv ====
// Serial master model standing for the host controller
`timescale 1ns/10ps
`default_nettype none
module spi_host_model
(
  input  wire logic clk_sys,
  output var logic  spi_cs_n,
  output var logic  spi_sck,
  output var logic  spi_sdi,
  input  wire logic spi_sdo,
  input  wire logic spi_sdo_oe
);
  logic cpol;
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_sdi = 1'b0;
    cpol = 1'b0;
  end
  // Mode and idle level change only while deselected
  task automatic start(input logic mode);
    cpol = mode;
    spi_sck = mode;
    repeat (5) @(negedge clk_sys);
    spi_cs_n = 1'b0;
    repeat (5) @(negedge clk_sys);
  endtask
  task automatic stop();
    repeat (5) @(negedge clk_sys);
    spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;
    repeat (5) @(negedge clk_sys);
  endtask
  // Five system clocks per level keeps the serial clock at 5 MHz
  task automatic xfer(input logic [7:0] tx, input logic toggle, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      if (cpol)
        spi_sck = 1'b0;
      spi_sdi = toggle ? ~spi_sdi : tx[i];
      repeat (5) @(negedge clk_sys);
      spi_sck = 1'b1;
      // A floating output reads back inverted so an undriven bit cannot pass
      rx[i] = (spi_sdo_oe === 1'b1) ? spi_sdo : ~spi_sdo;
      repeat (5) @(negedge clk_sys);
      if (!cpol)
        spi_sck = 1'b0;
    end
  endtask
endmodule // spi_host_model
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the front-end pin logic
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       clk_sys, reset, external_clock_select, crystal_in, ready_pin_drive_select;
  logic       tx_valid, xtal_run;
  logic [1:0] prescale_select, modulator_stream, modulator_output_enable;
  logic [2:0] oversampling_ratio;
  logic [7:0] tx_data, cmd_seen, rx_seen, rd;
  wire        spi_cs_n, spi_sck, spi_sdi, spi_sdo, spi_sdo_oe, crystal_out, tx_ready;
  wire        sample_tick, output_rate_tick, conversion_ready_n, conversion_ready_n_oe;
  wire        modulator_bit_out_ch0, modulator_bit_out_ch0_oe, modulator_bit_out_ch1;
  wire        modulator_bit_out_ch1_oe, cmd_valid, rx_valid, frame_end;
  wire  [7:0] cmd_byte, rx_byte;
  int         failures, tests_run, cyc, n_cmd, n, p, o;
  afe_clock_ready_serial_pins i_dut (.clk_sys, .reset, .external_clock_select, .crystal_in,
    .crystal_out, .prescale_select, .oversampling_ratio, .sample_tick, .output_rate_tick,
    .modulator_stream, .modulator_output_enable, .modulator_bit_out_ch0,
    .modulator_bit_out_ch0_oe, .modulator_bit_out_ch1, .modulator_bit_out_ch1_oe,
    .ready_pin_drive_select, .conversion_ready_n, .conversion_ready_n_oe, .spi_cs_n,
    .spi_sck, .spi_sdi, .spi_sdo, .spi_sdo_oe, .cmd_byte, .cmd_valid, .rx_byte, .rx_valid,
    .frame_end, .tx_data, .tx_valid, .tx_ready);
  spi_host_model i_host (.clk_sys, .spi_cs_n, .spi_sck, .spi_sdi, .spi_sdo, .spi_sdo_oe);
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always
  begin
    repeat (8) @(negedge clk_sys);
    if (xtal_run)
      crystal_in = ~crystal_in;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cmd_valid === 1'b1)
    begin
      cmd_seen <= cmd_byte;
      n_cmd++;
    end
    if (rx_valid === 1'b1)
      rx_seen <= rx_byte;
    if (cyc == 90000)
    begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Settings change only under reset so every divider restarts aligned
  task automatic setup(input int sp, input int so, input logic e, input logic d);
    reset = 1'b1;
    prescale_select = 2'(sp);
    oversampling_ratio = 3'(so);
    external_clock_select = e;
    ready_pin_drive_select = d;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
  endtask
  task automatic tick_gap(output int g);
    g = 0;
    do
    begin
      @(negedge clk_sys);
      g++;
    end
    while (sample_tick !== 1'b1 && g < 200);
  endtask
  task automatic to_fall(output int t);
    t = 0;
    while (conversion_ready_n !== 1'b1 && t < 40000)
    begin
      @(negedge clk_sys);
      t++;
    end
    while (conversion_ready_n !== 1'b0 && t < 40000)
    begin
      @(negedge clk_sys);
      t++;
    end
  endtask
  // Valid stays up between back-to-back pushes; the caller lowers it after the last one
  task automatic push(input logic [7:0] d);
    tx_data = d;
    tx_valid = 1'b1;
    do
      @(posedge clk_sys);
    while (tx_ready !== 1'b1);
    @(negedge clk_sys);
  endtask
  initial
  begin
    reset = 1'b1;
    {external_clock_select, crystal_in, ready_pin_drive_select, tx_valid, xtal_run} = 5'h00;
    {prescale_select, modulator_stream, modulator_output_enable} = 6'h00;
    oversampling_ratio = 3'h3;
    tx_data = 8'h00;
    repeat (12) @(negedge clk_sys);
    reset = 1'b0;
    for (int k = 0; k < 11; k++)
    begin
      p = (k < 8) ? 0 : k - 7;
      o = (k < 8) ? k : 0;
      setup(p, o, 1'b0, k[0]);
      tick_gap(n);
      tick_gap(n);
      chk("sample gap", 16'(n), 16'(4 << p));
      to_fall(n);
      to_fall(n);
      chk("ready period", 16'(n), 16'(128 << (p + o)));
      repeat ((4 << p) + 3) @(negedge clk_sys);
      chk("ready idle oe", 16'(conversion_ready_n_oe), 16'(k[0]));
    end
    setup(0, 0, 1'b1, 1'b1);
    xtal_run = 1'b1;
    tick_gap(n);
    tick_gap(n);
    chk("crystal gap", 16'(n), 16'h0040);
    chk("crystal out ext", 16'(crystal_out), 16'h0000);
    xtal_run = 1'b0;
    setup(0, 0, 1'b0, 1'b1);
    for (int e = 2; e >= 0; e--)
    begin
      modulator_output_enable = 2'(e);
      modulator_stream = 2'(3 - e);
      repeat (10) @(negedge clk_sys);
      chk("mod oe", {modulator_bit_out_ch1_oe, modulator_bit_out_ch0_oe}, 16'(e));
      chk("mod bit", {modulator_bit_out_ch1, modulator_bit_out_ch0}, 16'(3 - e));
    end
    chk("crystal out", 16'(crystal_out), 16'(!crystal_in));
    n = n_cmd;
    i_host.xfer(8'h81, 1'b0, rd);
    chk("deselected cmd", 16'(n_cmd), 16'(n));
    i_host.start(1'b0);
    i_host.xfer(8'h52, 1'b0, rd);
    i_host.xfer(8'hA5, 1'b0, rd);
    i_host.stop();
    chk("write cmd", cmd_seen, 8'h52);
    chk("write data", rx_seen, 8'hA5);
    for (int i = 0; i < 16; i++)
      push(8'h30 + 8'(i));
    tx_valid = 1'b0;
    chk("fifo full", tx_ready, 1'b0);
    i_host.start(1'b1);
    i_host.xfer(8'h01, 1'b0, rd);
    for (int i = 0; i < 17; i++)
    begin
      i_host.xfer(8'h00, 1'b1, rd);
      chk("read byte", rd, (i < 16) ? 8'h30 + 8'(i) : 8'h00);
    end
    i_host.stop();
    chk("fifo empty", tx_ready, 1'b1);
    chk("read cmd", cmd_seen, 8'h01);
    chk("read rx", rx_seen, 8'hA5);
    wrap_up();
  end
endmodule // tb
bind afe_clock_ready_serial_pins afe_pins_asserts i_chk (.clk_sys, .reset,
  .external_clock_select, .prescale_select, .sample_tick, .output_rate_tick,
  .modulator_output_enable, .modulator_bit_out_ch0_oe, .modulator_bit_out_ch1_oe,
  .ready_pin_drive_select, .conversion_ready_n, .conversion_ready_n_oe, .spi_sdo_oe,
  .cmd_byte, .cmd_valid, .rx_valid, .frame_end);
`default_nettype wire
